/* File: include/alarm_pkg.sv */
// Shared constants for the converter result formatter and alarm monitor
package alarm_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int CODE_W = 18;
  localparam int CODE_STEPS = 262144;
  localparam int AUX_W = 16;
  localparam int HYS_W = 8;
  localparam int CMP_W = CODE_W + 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 2 * NUM_CH;
  localparam int EDGE_CNT_W = 6;
  localparam int FRAME_CNT_W = 16;
  localparam int MV_W = 16;

  // Serial clock falling edge on which the alert pin may change
  localparam logic [EDGE_CNT_W-1:0] ALERT_EDGE = 6'h10;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_MAX = 6'h3f;

  // Positive full-scale limits in millivolts
  localparam logic [MV_W-1:0] PFS_10V24_MV = 16'h2800;
  localparam logic [MV_W-1:0] PFS_5V12_MV = 16'h1400;
  localparam logic [MV_W-1:0] PFS_2V56_MV = 16'h0a00;

  // Range select encodings
  localparam logic [3:0] RNG_BI_2P5 = 4'h0;
  localparam logic [3:0] RNG_BI_1P25 = 4'h1;
  localparam logic [3:0] RNG_BI_0P625 = 4'h2;
  localparam logic [3:0] RNG_UNI_2P5 = 4'h5;
  localparam logic [3:0] RNG_UNI_1P25 = 4'h6;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TRIPPED = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_AUX = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FRAME = 8'h05;
  localparam logic [ADDR_W-1:0] CH_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] CH_MASK = 8'hc0;
  localparam int CH_FLD_W = 3;
  localparam logic [CH_FLD_W-1:0] FLD_HI_THR = 3'h0;
  localparam logic [CH_FLD_W-1:0] FLD_HI_HYS = 3'h1;
  localparam logic [CH_FLD_W-1:0] FLD_LO_THR = 3'h2;
  localparam logic [CH_FLD_W-1:0] FLD_LO_HYS = 3'h3;
  localparam logic [CH_FLD_W-1:0] FLD_RANGE = 3'h4;
  localparam logic [CH_FLD_W-1:0] FLD_RESULT = 3'h5;

  // Field positions
  localparam int FLAG_LO_LSB = NUM_CH;
  localparam int RNG_BIPOLAR_BIT = 4;
  localparam int RNG_SPAN_LSB = 16;
  localparam int FRAME_CNT_LSB = 16;

  // Reset values
  localparam logic [CODE_W-1:0] HI_THR_RST = 18'h3ffff;
  localparam logic [CODE_W-1:0] LO_THR_RST = 18'h00000;
  localparam logic [HYS_W-1:0] HYS_RST = 8'h00;
  localparam logic [3:0] RANGE_RST = 4'h0;
endpackage

/* File: include/alarm_if.sv */
// Interfaces between the monitor top and its comparator and link front end
`timescale 1ns/100ps
interface alarm_cmp_if;
  logic update;
  logic [alarm_pkg::CODE_W-1:0] code;
  logic [alarm_pkg::CODE_W-1:0] hi_thr;
  logic [alarm_pkg::CODE_W-1:0] lo_thr;
  logic [alarm_pkg::HYS_W-1:0] hi_hys;
  logic [alarm_pkg::HYS_W-1:0] lo_hys;
  logic hi_active;
  logic lo_active;
  logic hi_hit;
  logic lo_hit;
  modport ctrl (output update, code, hi_thr, lo_thr, hi_hys, lo_hys,
                input hi_active, lo_active, hi_hit, lo_hit);
  modport cmp (input update, code, hi_thr, lo_thr, hi_hys, lo_hys,
               output hi_active, lo_active, hi_hit, lo_hit);
endinterface

interface link_edge_if;
  logic sclk_fall;
  logic frame_start;
  logic frame_active;
  modport src (output sclk_fall, frame_start, frame_active);
  modport sink (input sclk_fall, frame_start, frame_active);
endinterface

/* File: design/alarm_channel.sv */
// High and low threshold comparator with hysteresis for one channel
`timescale 1ns/100ps
module alarm_channel (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  alarm_cmp_if.cmp cmp
);
  typedef struct packed {
    logic hi_active;
    logic lo_active;
    logic hi_hit;
    logic lo_hit;
  } chan_state_type;

  chan_state_type st_r;
  chan_state_type st_nxt;

  // Signed and widened so threshold minus hysteresis near zero cannot wrap
  logic signed [alarm_pkg::CMP_W-1:0] code_s;
  logic signed [alarm_pkg::CMP_W-1:0] hi_up;
  logic signed [alarm_pkg::CMP_W-1:0] hi_dn;
  logic signed [alarm_pkg::CMP_W-1:0] lo_dn;
  logic signed [alarm_pkg::CMP_W-1:0] lo_up;

  always_comb begin
    code_s = $signed({3'h0, cmp.code});
    hi_up = $signed({3'h0, cmp.hi_thr}) + $signed({13'h0, cmp.hi_hys});
    hi_dn = $signed({3'h0, cmp.hi_thr}) - $signed({13'h0, cmp.hi_hys}) - 21'sh2;
    lo_dn = $signed({3'h0, cmp.lo_thr}) - $signed({13'h0, cmp.lo_hys}) - 21'sh1;
    lo_up = $signed({3'h0, cmp.lo_thr}) + $signed({13'h0, cmp.lo_hys}) + 21'sh1;
    st_nxt = st_r;
    st_nxt.hi_hit = 1'b0;
    st_nxt.lo_hit = 1'b0;
    if (cmp.update) begin
      if (code_s > hi_up) begin
        st_nxt.hi_active = 1'b1;
        st_nxt.hi_hit = 1'b1;
      end else if (code_s <= hi_dn) begin
        st_nxt.hi_active = 1'b0;
      end
      if (code_s < lo_dn) begin
        st_nxt.lo_active = 1'b1;
        st_nxt.lo_hit = 1'b1;
      end else if (code_s >= lo_up) begin
        st_nxt.lo_active = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign cmp.hi_active = st_r.hi_active;
  assign cmp.lo_active = st_r.lo_active;
  assign cmp.hi_hit = st_r.hi_hit;
  assign cmp.lo_hit = st_r.lo_hit;
endmodule // alarm_channel

/* File: design/sclk_edge.sv */
// Serial clock and chip select synchroniser with frame edge detection
`timescale 1ns/100ps
module sclk_edge (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  link_edge_if.src lnk
);
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s1 = i_sclk;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_s3 = st_r.sclk_s2;
    st_nxt.cs_s1 = i_cs_n;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.cs_s3 = st_r.cs_s2;
  end

  // Chip select idles high so no frame is seen while reset holds
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r <= '0;
      st_r.cs_s1 <= 1'b1;
      st_r.cs_s2 <= 1'b1;
      st_r.cs_s3 <= 1'b1;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.sclk_fall = st_r.sclk_s3 & ~st_r.sclk_s2 & ~st_r.cs_s2;
  assign lnk.frame_start = st_r.cs_s3 & ~st_r.cs_s2;
  assign lnk.frame_active = ~st_r.cs_s2;
endmodule // sclk_edge

/* File: design/adc_code_alarm_monitor.sv */
// Result formatting, per-channel alarm flags, alert pin and register file
//
// Contract
// - Results leave in straight binary, same format on every channel and range.
// - Main-channel results are 18 bits; one step is span over 262144.
// - Span is positive minus negative full scale; 20.48, 10.24 or 5.12 V.
// - Auxiliary result is 16-bit unipolar, bypassing range handling.
// - Alert output is active high.
// - Alert changes only on the 16th falling serial clock edge of a frame.
// - Alert takes the OR of all channels' tripped flags at that edge.
// - Each channel has high and low thresholds each with own hysteresis.
// - High alarm sets when code exceeds high threshold plus hysteresis.
// - High alarm clears at code at or below threshold minus hysteresis minus 2.
// - Low alarm sets when code below low threshold minus hysteresis minus 1.
// - Low alarm clears at code at or above threshold plus hysteresis plus 1.
// - Active flags follow the alarm state live.
// - Tripped flags set with active, latch, clear when flag register read.
// - Range field decodes 0,1,2 as bipolar, 5,6 as unipolar ranges.
`timescale 1ns/100ps
module adc_code_alarm_monitor (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [alarm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [alarm_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [alarm_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_conv_valid,
  input wire logic [alarm_pkg::CH_W-1:0] i_conv_chan,
  input wire logic [alarm_pkg::CODE_W-1:0] i_conv_code,
  input wire logic i_aux_valid,
  input wire logic [alarm_pkg::AUX_W-1:0] i_aux_code,
  output logic o_result_valid,
  output logic [alarm_pkg::CH_W-1:0] o_result_chan,
  output logic [alarm_pkg::CODE_W-1:0] o_result_code,
  output logic o_alert,
  output logic o_irq
);
  localparam int N = alarm_pkg::NUM_CH;

  typedef struct packed {
    logic [N-1:0][alarm_pkg::CODE_W-1:0] hi_thr;
    logic [N-1:0][alarm_pkg::CODE_W-1:0] lo_thr;
    logic [N-1:0][alarm_pkg::HYS_W-1:0] hi_hys;
    logic [N-1:0][alarm_pkg::HYS_W-1:0] lo_hys;
    logic [N-1:0][3:0] channel_range_select;
    logic [N-1:0][alarm_pkg::CODE_W-1:0] result;
    logic [N-1:0] upd;
    logic [alarm_pkg::FLAG_W-1:0] tripped;
    logic [alarm_pkg::FLAG_W-1:0] irq_stat;
    logic [alarm_pkg::FLAG_W-1:0] irq_mask;
    logic [alarm_pkg::AUX_W-1:0] aux;
    logic [alarm_pkg::EDGE_CNT_W-1:0] edge_cnt;
    logic [alarm_pkg::FRAME_CNT_W-1:0] frame_cnt;
    logic alert;
    logic [alarm_pkg::DATA_W-1:0] rdata;
    logic res_valid;
    logic [alarm_pkg::CH_W-1:0] res_chan;
    logic [alarm_pkg::CODE_W-1:0] res_code;
  } mon_state_type;

  mon_state_type st_r;
  mon_state_type st_nxt;

  logic [N-1:0] hi_active;
  logic [N-1:0] lo_active;
  logic [N-1:0] hi_hit;
  logic [N-1:0] lo_hit;
  logic [alarm_pkg::FLAG_W-1:0] hits;
  logic [alarm_pkg::FLAG_W-1:0] active;

  link_edge_if lnk ();

  sclk_edge u_sclk_edge (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .lnk(lnk)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ch
      alarm_cmp_if cmp_bus ();
      assign cmp_bus.update = st_r.upd[g];
      assign cmp_bus.code = st_r.result[g];
      assign cmp_bus.hi_thr = st_r.hi_thr[g];
      assign cmp_bus.lo_thr = st_r.lo_thr[g];
      assign cmp_bus.hi_hys = st_r.hi_hys[g];
      assign cmp_bus.lo_hys = st_r.lo_hys[g];
      assign hi_active[g] = cmp_bus.hi_active;
      assign lo_active[g] = cmp_bus.lo_active;
      assign hi_hit[g] = cmp_bus.hi_hit;
      assign lo_hit[g] = cmp_bus.lo_hit;
      alarm_channel u_chan (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .cmp(cmp_bus)
      );
    end
  endgenerate

  assign hits = {lo_hit, hi_hit};
  assign active = {lo_active, hi_active};

  // Returns {bipolar, positive full scale in mV}; unlisted codes act as the widest range
  function automatic logic [alarm_pkg::MV_W:0] range_info(input logic [3:0] sel);
    logic [alarm_pkg::MV_W:0] r;
    r = {1'b1, alarm_pkg::PFS_10V24_MV};
    case (sel)
      alarm_pkg::RNG_BI_2P5: r = {1'b1, alarm_pkg::PFS_10V24_MV};
      alarm_pkg::RNG_BI_1P25: r = {1'b1, alarm_pkg::PFS_5V12_MV};
      alarm_pkg::RNG_BI_0P625: r = {1'b1, alarm_pkg::PFS_2V56_MV};
      alarm_pkg::RNG_UNI_2P5: r = {1'b0, alarm_pkg::PFS_10V24_MV};
      alarm_pkg::RNG_UNI_1P25: r = {1'b0, alarm_pkg::PFS_5V12_MV};
      default: r = {1'b1, alarm_pkg::PFS_10V24_MV};
    endcase
    return r;
  endfunction

  // Span is PFS minus NFS: twice PFS when bipolar, PFS when unipolar
  function automatic logic [alarm_pkg::MV_W-1:0] span_mv(input logic [alarm_pkg::MV_W:0] ri);
    logic [alarm_pkg::MV_W-1:0] s;
    s = ri[alarm_pkg::MV_W] ? {ri[alarm_pkg::MV_W-2:0], 1'b0} : ri[alarm_pkg::MV_W-1:0];
    return s;
  endfunction

  logic is_ch;
  logic [alarm_pkg::CH_W-1:0] ch_idx;
  logic [alarm_pkg::CH_FLD_W-1:0] fld;
  logic [alarm_pkg::MV_W:0] sel_info;
  logic [alarm_pkg::MV_W:0] conv_info;
  logic [alarm_pkg::CODE_W-1:0] fmt_code;
  logic [alarm_pkg::FLAG_W-1:0] w1c;
  logic [alarm_pkg::FLAG_W-1:0] rd_clr;

  always_comb begin
    is_ch = (i_addr & alarm_pkg::CH_MASK) == alarm_pkg::CH_BASE;
    ch_idx = i_addr[alarm_pkg::CH_FLD_W +: alarm_pkg::CH_W];
    fld = i_addr[alarm_pkg::CH_FLD_W-1:0];
    sel_info = range_info(st_r.channel_range_select[ch_idx]);
    conv_info = range_info(st_r.channel_range_select[i_conv_chan]);
    // Core delivers two's complement on bipolar ranges; flipping the MSB gives offset binary
    fmt_code = conv_info[alarm_pkg::MV_W] ?
               {~i_conv_code[alarm_pkg::CODE_W-1], i_conv_code[alarm_pkg::CODE_W-2:0]} :
               i_conv_code;
    w1c = '0;
    rd_clr = '0;
    st_nxt = st_r;
    st_nxt.upd = '0;
    st_nxt.res_valid = 1'b0;
    st_nxt.rdata = '0;

    if (i_conv_valid) begin
      st_nxt.result[i_conv_chan] = fmt_code;
      st_nxt.upd[i_conv_chan] = 1'b1;
      st_nxt.res_valid = 1'b1;
      st_nxt.res_chan = i_conv_chan;
      st_nxt.res_code = fmt_code;
    end
    if (i_aux_valid) begin
      st_nxt.aux = i_aux_code;
    end

    if (i_wr) begin
      if (is_ch) begin
        case (fld)
          alarm_pkg::FLD_HI_THR: st_nxt.hi_thr[ch_idx] = i_wdata[alarm_pkg::CODE_W-1:0];
          alarm_pkg::FLD_HI_HYS: st_nxt.hi_hys[ch_idx] = i_wdata[alarm_pkg::HYS_W-1:0];
          alarm_pkg::FLD_LO_THR: st_nxt.lo_thr[ch_idx] = i_wdata[alarm_pkg::CODE_W-1:0];
          alarm_pkg::FLD_LO_HYS: st_nxt.lo_hys[ch_idx] = i_wdata[alarm_pkg::HYS_W-1:0];
          alarm_pkg::FLD_RANGE: st_nxt.channel_range_select[ch_idx] = i_wdata[3:0];
          default: st_nxt.aux = st_nxt.aux;
        endcase
      end else if (i_addr == alarm_pkg::ADDR_IRQ_STAT) begin
        w1c = i_wdata[alarm_pkg::FLAG_W-1:0];
      end else if (i_addr == alarm_pkg::ADDR_IRQ_MASK) begin
        st_nxt.irq_mask = i_wdata[alarm_pkg::FLAG_W-1:0];
      end
    end

    if (i_rd) begin
      if (is_ch) begin
        case (fld)
          alarm_pkg::FLD_HI_THR: st_nxt.rdata = 32'(st_r.hi_thr[ch_idx]);
          alarm_pkg::FLD_HI_HYS: st_nxt.rdata = 32'(st_r.hi_hys[ch_idx]);
          alarm_pkg::FLD_LO_THR: st_nxt.rdata = 32'(st_r.lo_thr[ch_idx]);
          alarm_pkg::FLD_LO_HYS: st_nxt.rdata = 32'(st_r.lo_hys[ch_idx]);
          alarm_pkg::FLD_RANGE: begin
            st_nxt.rdata[3:0] = st_r.channel_range_select[ch_idx];
            st_nxt.rdata[alarm_pkg::RNG_BIPOLAR_BIT] = sel_info[alarm_pkg::MV_W];
            st_nxt.rdata[alarm_pkg::RNG_SPAN_LSB +: alarm_pkg::MV_W] = span_mv(sel_info);
          end
          alarm_pkg::FLD_RESULT: st_nxt.rdata = 32'(st_r.result[ch_idx]);
          default: st_nxt.rdata = '0;
        endcase
      end else begin
        case (i_addr)
          alarm_pkg::ADDR_ACTIVE: st_nxt.rdata = 32'(active);
          alarm_pkg::ADDR_TRIPPED: begin
            st_nxt.rdata = 32'(st_r.tripped);
            rd_clr = '1;
          end
          alarm_pkg::ADDR_IRQ_STAT: st_nxt.rdata = 32'(st_r.irq_stat);
          alarm_pkg::ADDR_IRQ_MASK: st_nxt.rdata = 32'(st_r.irq_mask);
          alarm_pkg::ADDR_AUX: st_nxt.rdata = 32'(st_r.aux);
          alarm_pkg::ADDR_FRAME: begin
            st_nxt.rdata[alarm_pkg::EDGE_CNT_W-1:0] = st_r.edge_cnt;
            st_nxt.rdata[alarm_pkg::FRAME_CNT_LSB +: alarm_pkg::FRAME_CNT_W] = st_r.frame_cnt;
          end
          default: st_nxt.rdata = '0;
        endcase
      end
    end

    // A new hit in the clearing cycle survives the clear
    st_nxt.tripped = (st_r.tripped & ~rd_clr) | hits;
    st_nxt.irq_stat = (st_r.irq_stat & ~w1c) | hits;

    if (lnk.frame_start) begin
      st_nxt.edge_cnt = '0;
      st_nxt.frame_cnt = st_r.frame_cnt + 16'h0001;
    end else if (lnk.sclk_fall) begin
      if (st_r.edge_cnt != alarm_pkg::EDGE_CNT_MAX) begin
        st_nxt.edge_cnt = st_r.edge_cnt + 6'h01;
      end
      // Alert only moves on this edge, so a trip after it waits for the next frame
      if (st_r.edge_cnt + 6'h01 == alarm_pkg::ALERT_EDGE) begin
        st_nxt.alert = |st_r.tripped;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r <= '0;
      st_r.hi_thr <= {N{alarm_pkg::HI_THR_RST}};
      st_r.lo_thr <= {N{alarm_pkg::LO_THR_RST}};
      st_r.hi_hys <= {N{alarm_pkg::HYS_RST}};
      st_r.lo_hys <= {N{alarm_pkg::HYS_RST}};
      st_r.channel_range_select <= {N{alarm_pkg::RANGE_RST}};
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_alert = st_r.alert;
  assign o_irq = |(st_r.irq_stat & st_r.irq_mask);
  assign o_result_valid = st_r.res_valid;
  assign o_result_chan = st_r.res_chan;
  assign o_result_code = st_r.res_code;
endmodule // adc_code_alarm_monitor

/* File: bench/serial_host_model.sv */
// Serial host: frames chip select and clocks a chosen number of falling edges
`timescale 1ns/100ps
module serial_host_model (
  input wire logic i_start,
  input wire logic [5:0] i_falls,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_busy
);
  // Clock idles high and stands still between frames, so no stray falls are counted
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_busy = 1'b0;
  end
  always @(posedge i_start) begin
    o_busy = 1'b1;
    // Offset keeps every pin change clear of the system clock's rising edge
    #32 o_cs_n = 1'b0;
    #97;
    repeat (i_falls) begin
      #40 o_sclk = 1'b0;
      #40 o_sclk = 1'b1;
    end
    #57 o_cs_n = 1'b1;
    #200 o_busy = 1'b0;
  end
endmodule // serial_host_model

/* File: bench/alarm_monitor_chk.sv */
// Port-level assertions for the converter alarm monitor
`timescale 1ns/100ps
module alarm_monitor_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [alarm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [alarm_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [alarm_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_conv_valid,
  input wire logic [alarm_pkg::CH_W-1:0] i_conv_chan,
  input wire logic [alarm_pkg::CODE_W-1:0] i_conv_code,
  input wire logic i_aux_valid,
  input wire logic [alarm_pkg::AUX_W-1:0] i_aux_code,
  input wire logic o_result_valid,
  input wire logic [alarm_pkg::CH_W-1:0] o_result_chan,
  input wire logic [alarm_pkg::CODE_W-1:0] o_result_code,
  input wire logic o_alert,
  input wire logic o_irq
);
  logic sclk_q_r;
  logic [4:0] falls_r;
  logic [3:0] since_r;
  wire logic fell = sclk_q_r & ~i_sclk;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Pin-level edge count, kept apart from the design's own synchroniser
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      sclk_q_r <= 1'b1;
      falls_r <= 5'h00;
      since_r <= 4'hf;
    end else begin
      sclk_q_r <= i_sclk;
      if (i_cs_n) falls_r <= 5'h00;
      else if (fell) falls_r <= falls_r + 5'h01;
      if (fell && !i_cs_n && falls_r == 5'h0f) since_r <= 4'h0;
      else if (since_r != 4'hf) since_r <= since_r + 4'h1;
    end
  end
  sequence rd_trip_s;
    i_rd && i_addr == alarm_pkg::ADDR_TRIPPED;
  endsequence
  sequence quiet_reread_s;
    !i_conv_valid [*4] ##0 rd_trip_s ##1 rd_trip_s;
  endsequence
  sequence aux_read_s;
    i_aux_valid ##1 (i_rd && i_addr == alarm_pkg::ADDR_AUX && !i_aux_valid);
  endsequence
  AST_RESULT_VALID: assert property (o_result_valid == $past(i_conv_valid))
    else $error("result valid not one cycle after conversion");
  AST_RESULT_BITS: assert property (o_result_valid |->
    o_result_code[16:0] == $past(i_conv_code[16:0]) && o_result_chan == $past(i_conv_chan))
    else $error("result low bits or channel wrong");
  AST_RESULT_HOLD: assert property (!o_result_valid |->
    $stable(o_result_code) && $stable(o_result_chan))
    else $error("result changed without valid");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h00000000)
    else $error("read data not zero outside read answer");
  AST_FLAG_UPPER: assert property (i_rd && i_addr <= alarm_pkg::ADDR_IRQ_STAT |=>
    o_rdata[31:16] == 16'h0000)
    else $error("flag register upper bits set");
  AST_UNMAPPED: assert property (i_rd && i_addr inside {[8'h06:8'h3f]} |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_TRIP_READ: assert property (quiet_reread_s |=> o_rdata == 32'h00000000)
    else $error("tripped flags survived a read");
  AST_ALERT_EDGE: assert property ($changed(o_alert) |-> since_r inside {[1:6]})
    else $error("alert moved away from sixteenth serial fall");
  AST_AUX_READ: assert property (aux_read_s |=> o_rdata == {16'h0000, $past(i_aux_code, 2)})
    else $error("aux result not stored as given");
endmodule // alarm_monitor_chk

bind adc_code_alarm_monitor alarm_monitor_chk u_chk (.i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_conv_valid(i_conv_valid), .i_conv_chan(i_conv_chan), .i_conv_code(i_conv_code),
  .i_aux_valid(i_aux_valid), .i_aux_code(i_aux_code), .o_result_valid(o_result_valid),
  .o_result_chan(o_result_chan), .o_result_code(o_result_code), .o_alert(o_alert),
  .o_irq(o_irq));

/* File: bench/test_adc_code_alarm_monitor.sv */
// Register-level tests of result formatting, alarms, interrupt and alert pin
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_adc_code_alarm_monitor;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cv = 1'b0, av = 1'b0, go = 1'b0;
  logic en = 1'b1;
  logic sclk, cs_n, busy, rv, alert, irq;
  logic [5:0] falls = 6'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] cch = 3'h0, rch;
  logic [17:0] ccode = 18'h0, rcode;
  logic [15:0] acode = 16'h0;
  logic [3:0] rng [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
  logic [15:0] span [5] = '{16'h5000, 16'h2800, 16'h1400, 16'h2800, 16'h1400};
  int err_count = 0, total_checks = 0, k;
  serial_host_model i_host (.i_start(go), .i_falls(falls), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_busy(busy));
  adc_code_alarm_monitor i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(en),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_conv_valid(cv), .i_conv_chan(cch), .i_conv_code(ccode),
    .i_aux_valid(av), .i_aux_code(acode), .o_result_valid(rv), .o_result_chan(rch),
    .o_result_code(rcode), .o_alert(alert), .o_irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] ca(input logic [2:0] ch, input logic [2:0] f);
    return alarm_pkg::CH_BASE + {2'b00, ch, f};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Bipolar cores deliver two's complement; the pin format flips only the sign bit
  task automatic conv(input logic [2:0] ch, input logic [17:0] c, input logic bip);
    @(posedge clk);
    cv <= 1'b1;
    cch <= ch;
    ccode <= c;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    `CHK(rv, 1'b1)
    `CHK(rch, ch)
    `CHK(rcode, bip ? {~c[17], c[16:0]} : c)
    repeat (4) @(posedge clk);
  endtask
  task automatic frame(input logic [5:0] n);
    @(posedge clk);
    falls <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ca(3'h0, alarm_pkg::FLD_HI_THR), 32'h0003ffff);
    rd_chk(ca(3'h0, alarm_pkg::FLD_LO_THR), 32'h0);
    for (k = 0; k < 5; k++) begin
      wr_reg(ca(k[2:0], alarm_pkg::FLD_RANGE), {28'h0, rng[k]});
      rd_chk(ca(k[2:0], alarm_pkg::FLD_RANGE), {span[k], 11'h0, rng[k] < 4'h4, rng[k]});
      conv(k[2:0], 18'h20000, rng[k] < 4'h4);
      conv(k[2:0], 18'h1ffff, rng[k] < 4'h4);
      rd_chk(ca(k[2:0], alarm_pkg::FLD_RESULT), {14'h0, rng[k] < 4'h4 ? 18'h3ffff : 18'h1ffff});
    end
    wr_reg(ca(3'h3, alarm_pkg::FLD_HI_THR), 32'h100);
    wr_reg(ca(3'h3, alarm_pkg::FLD_HI_HYS), 32'h4);
    wr_reg(ca(3'h4, alarm_pkg::FLD_LO_THR), 32'h100);
    wr_reg(ca(3'h4, alarm_pkg::FLD_LO_HYS), 32'h3);
    rd_chk(ca(3'h4, alarm_pkg::FLD_LO_HYS), 32'h3);
    conv(3'h3, 18'h104, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h0);
    conv(3'h3, 18'h105, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h8);
    conv(3'h3, 18'h0fb, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h8);
    conv(3'h3, 18'h0fa, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h0);
    conv(3'h4, 18'h0fc, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h0);
    conv(3'h4, 18'h0fb, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h1000);
    conv(3'h4, 18'h103, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h1000);
    conv(3'h4, 18'h104, 1'b0);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h0);
    // Two reads with no gap: the second must see the flags already cleared
    @(posedge clk);
    rd <= 1'b1;
    addr <= alarm_pkg::ADDR_TRIPPED;
    @(posedge clk);
    #1;
    `CHK(rdata, 32'h1008)
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, 32'h0)
    rd_chk(alarm_pkg::ADDR_IRQ_STAT, 32'h1008);
    `CHK(irq, 1'b0)
    wr_reg(alarm_pkg::ADDR_IRQ_MASK, 32'h8);
    rd_chk(alarm_pkg::ADDR_IRQ_MASK, 32'h8);
    `CHK(irq, 1'b1)
    wr_reg(alarm_pkg::ADDR_IRQ_STAT, 32'h8);
    `CHK(irq, 1'b0)
    rd_chk(alarm_pkg::ADDR_IRQ_STAT, 32'h1000);
    conv(3'h3, 18'h105, 1'b0);
    frame(6'h0f);
    `CHK(alert, 1'b0)
    frame(6'h10);
    `CHK(alert, 1'b1)
    rd_chk(alarm_pkg::ADDR_TRIPPED, 32'h8);
    conv(3'h3, 18'h0fa, 1'b0);
    `CHK(alert, 1'b1)
    frame(6'h10);
    `CHK(alert, 1'b0)
    rd_chk(alarm_pkg::ADDR_FRAME, 32'h00030010);
    rd_chk(8'h20, 32'h0);
    wr_reg(alarm_pkg::ADDR_ACTIVE, 32'hffff);
    rd_chk(alarm_pkg::ADDR_ACTIVE, 32'h0);
    // A write while the clock enable is low must leave the mask untouched
    @(posedge clk);
    en <= 1'b0;
    wr_reg(alarm_pkg::ADDR_IRQ_MASK, 32'hffff);
    @(posedge clk);
    en <= 1'b1;
    rd_chk(alarm_pkg::ADDR_IRQ_MASK, 32'h8);
    @(posedge clk);
    av <= 1'b1;
    acode <= 16'hbeef;
    @(posedge clk);
    av <= 1'b0;
    rd <= 1'b1;
    addr <= alarm_pkg::ADDR_AUX;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, 32'h0000beef)
    tally_and_finish();
  end
endmodule // test_adc_code_alarm_monitor
